//--- hw/pvs_pkg.sv
// Purpose: shared constants and types for the phy vendor status latch registers
// Assumes: register access is the ulpi register read/write seen from the phy side
// Notes:   8-bit registers, printed offsets used directly
package pvs_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] PVS_ADDR_TUNE_CLR = 8'h82;
   localparam logic [7:0] PVS_ADDR_STATUS   = 8'h83;
   localparam logic [7:0] PVS_ADDR_LATCH    = 8'h84;

   // ------------------------------------------------------------
   // tuning register fields and reset values
   // ------------------------------------------------------------
   localparam int         PVS_TUNE_SPARE_BIT    = 7;
   localparam int         PVS_TUNE_POLARITY_BIT = 6;
   localparam int         PVS_TUNE_IMP_LSB      = 4;
   localparam int         PVS_TUNE_DRV_LSB      = 0;
   localparam logic [0:0] PVS_TUNE_SPARE_RST    = 1'h0;
   localparam logic [0:0] PVS_TUNE_POLARITY_RST = 1'h1;
   localparam logic [1:0] PVS_TUNE_IMP_RST      = 2'h0;
   localparam logic [3:0] PVS_TUNE_DRV_RST      = 4'h1;
   localparam logic [7:0] PVS_TUNE_RST          = {PVS_TUNE_SPARE_RST, PVS_TUNE_POLARITY_RST,
                                                   PVS_TUNE_IMP_RST, PVS_TUNE_DRV_RST};

   // ------------------------------------------------------------
   // status / latch layout and reset
   // ------------------------------------------------------------
   localparam int         PVS_SRC_W     = 7;
   localparam logic [6:0] PVS_LATCH_RST = 7'h00;
   localparam logic [7:0] PVS_RDATA_RST = 8'h00;

   typedef struct packed {
      logic bus_power_monitor_ok;      // bit 6
      logic abnormal_stress_flag;      // bit 5
      logic id_pin_floating;           // bit 4
      logic id_resistor_band_c;        // bit 3
      logic id_resistor_band_b;        // bit 2
      logic id_resistor_band_a;        // bit 1
      logic session_valid_comparator;  // bit 0
   } pvs_src_type;

   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pvs_req_type;

endpackage

//--- hw/pvs_latch_bit.sv
// Purpose: one sticky event bit of the latch register
// Assumes: set and clear are single-cycle qualifiers from the register block
// Notes:   set wins over clear so no event is lost
`timescale 1ns/1ps
`default_nettype none
module pvs_latch_bit
   import pvs_pkg::*;
#(
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk_i,
   input  wire logic rstn_i,
   input  wire logic set_i,
   input  wire logic clr_i,
   output var  logic q_o
);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         q_o <= RST_VAL;
      end else if (set_i) begin
         q_o <= 1'b1;
      end else if (clr_i) begin
         q_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

//--- hw/pvs_regs.sv
// Purpose: tuning clear alias, live source status and event latch registers
// Assumes: ulpi register access decoded to rd/wr strobes, one cycle each
// Notes:   read data answers one cycle after the strobe
//
// Function
// - writing one clears matching tuning bits
// - alias has no storage, reads tuning register
// - status is read-only live source levels
// - status bits six..zero map sources, bit7 zero
// - session bit is comparator output directly
// - unmasked source change sets latch bit
// - latch uses status mapping, bit7 zero
// - reading latch clears all its bits
// - low-power entry clears all latch bits
// - serial entry clears latch, suspend control ignored
// - event coinciding with read stays latched
`timescale 1ns/1ps
`default_nettype none
module pvs_regs
   import pvs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rstn_i,
   input  wire pvs_req_type req_i,
   input  wire pvs_src_type src_i,
   input  wire logic [6:0]  rise_en_i,
   input  wire logic [6:0]  fall_en_i,
   input  wire logic        lowpower_entry_i,
   input  wire logic        serial_entry_i,
   input  wire logic        clock_suspend_control_i,
   output var  logic [7:0]  rdata_o,
   output var  logic        rvalid_o,
   output var  logic [7:0]  tx_tuning_o
);

   // ------------------------------------------------------------
   // source edge detection
   // ------------------------------------------------------------
   logic [6:0] src_prev_r;
   logic [6:0] src_chg;
   logic [6:0] latch_q;
   logic       latch_clr;
   logic       rd_alias;
   logic       rd_status;
   logic       rd_latch;
   logic       wr_alias;

   assign rd_alias  = req_i.rd && (req_i.addr == PVS_ADDR_TUNE_CLR);
   assign rd_status = req_i.rd && (req_i.addr == PVS_ADDR_STATUS);
   assign rd_latch  = req_i.rd && (req_i.addr == PVS_ADDR_LATCH);
   assign wr_alias  = req_i.wr && (req_i.addr == PVS_ADDR_TUNE_CLR);

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         src_prev_r <= PVS_LATCH_RST;
      end else begin
         src_prev_r <= src_i;
      end
   end

   assign src_chg = (src_i & ~src_prev_r & rise_en_i) | (~src_i & src_prev_r & fall_en_i);

   assign latch_clr = rd_latch || lowpower_entry_i || serial_entry_i;

   // ------------------------------------------------------------
   // latch register bits
   // ------------------------------------------------------------
   // per-bit cell, set beats clear
   for (genvar i = 0; i < PVS_SRC_W; i++) begin : g_latch
      pvs_latch_bit #(
         .RST_VAL (PVS_LATCH_RST[i])
      ) u_bit (
         .clk_i  (clk_i),
         .rstn_i (rstn_i),
         .set_i  (src_chg[i]),
         .clr_i  (latch_clr),
         .q_o    (latch_q[i])
      );
   end

   // ------------------------------------------------------------
   // tuning register behind the clear alias
   // ------------------------------------------------------------
   // the alias itself stores nothing; writes act on this register
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_tuning_o <= PVS_TUNE_RST;
      end else if (wr_alias) begin
         tx_tuning_o <= tx_tuning_o & ~req_i.wdata;
      end
   end

   // ------------------------------------------------------------
   // read data path
   // ------------------------------------------------------------
   // unmapped reads answer zero so the link never sees stale data
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_o <= PVS_RDATA_RST;
      end else if (rd_alias) begin
         rdata_o <= tx_tuning_o;
      end else if (rd_status) begin
         rdata_o <= {1'b0, src_i};
      end else if (rd_latch) begin
         rdata_o <= {1'b0, latch_q};
      end else if (req_i.rd) begin
         rdata_o <= PVS_RDATA_RST;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_latch_read;
      rd_latch && (src_chg == 7'h00);
   endsequence

   sequence s_latch_empty;
      latch_q == 7'h00;
   endsequence

   property p_alias_clear;
      @(posedge clk_i) disable iff (!rstn_i)
      wr_alias |=> tx_tuning_o == ($past(tx_tuning_o) & ~$past(req_i.wdata));
   endproperty
   a_alias_clear: assert property (p_alias_clear) else $error("alias clear wrong");

   property p_alias_read;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_alias |=> rvalid_o && (rdata_o == $past(tx_tuning_o));
   endproperty
   a_alias_read: assert property (p_alias_read) else $error("alias read wrong");

   property p_status_live;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_status |=> rvalid_o && (rdata_o[6:0] == $past(src_i));
   endproperty
   a_status_live: assert property (p_status_live) else $error("status not live");

   property p_status_top;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_status |=> !rdata_o[7];
   endproperty
   a_status_top: assert property (p_status_top) else $error("status bit7 set");

   property p_session_bit;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_status |=> rdata_o[0] == $past(src_i.session_valid_comparator);
   endproperty
   a_session_bit: assert property (p_session_bit) else $error("session bit wrong");

   property p_latch_set;
      @(posedge clk_i) disable iff (!rstn_i)
      (src_chg != 7'h00) |=> ((latch_q & $past(src_chg)) == $past(src_chg));
   endproperty
   a_latch_set: assert property (p_latch_set) else $error("event not latched");

   property p_latch_read;
      @(posedge clk_i) disable iff (!rstn_i)
      s_latch_read |=> s_latch_empty and (rdata_o == {1'b0, $past(latch_q)});
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch read wrong");

   property p_latch_top;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_latch |=> !rdata_o[7];
   endproperty
   a_latch_top: assert property (p_latch_top) else $error("latch bit7 set");

   property p_lowpower_clr;
      @(posedge clk_i) disable iff (!rstn_i)
      lowpower_entry_i && (src_chg == 7'h00) |=> s_latch_empty;
   endproperty
   a_lowpower_clr: assert property (p_lowpower_clr) else $error("lp no clear");

   property p_serial_clr;
      @(posedge clk_i) disable iff (!rstn_i)
      serial_entry_i && (src_chg == 7'h00) |=> s_latch_empty;
   endproperty
   a_serial_clr: assert property (p_serial_clr) else $error("serial no clear");

   // suspend control must not hold the clear back
   property p_ser_susp;
      @(posedge clk_i) disable iff (!rstn_i)
      serial_entry_i && clock_suspend_control_i && (src_chg == 7'h00) |=> s_latch_empty;
   endproperty
   a_ser_susp: assert property (p_ser_susp) else $error("serial susp no clear");

   property p_read_race;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_latch && (src_chg != 7'h00) |=> latch_q == $past(src_chg);
   endproperty
   a_read_race: assert property (p_read_race) else $error("race event lost");

   property p_preclear;
      @(posedge clk_i) disable iff (!rstn_i)
      rd_latch ##1 rvalid_o |-> rdata_o[6:0] == $past(latch_q);
   endproperty
   a_preclear: assert property (p_preclear) else $error("read not pre-clear");

endmodule
`default_nettype wire

//--- sim/pvs_link_model.sv
// Purpose: link controller side of the register access
// Assumes: one request per task call, idle cycle between calls
// Notes:   released address/data show the inverse, not a stale copy
`timescale 1ns/1ps
`default_nettype none
module pvs_link_model
   import pvs_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic [7:0]  rdata_i,
   input  wire logic        rvalid_i,
   output var  pvs_req_type req_o
);
   initial req_o = '0;

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b1, a, d};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, ~d};
      // let the taking edge settle before anyone looks at the tuning value
      @(posedge clk_i);
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge clk_i);
      req_o <= '{1'b1, 1'b0, a, 8'h00};
      @(posedge clk_i);
      req_o <= '{1'b0, 1'b0, ~a, 8'hff};
      // answer stands for the cycle after the taking edge; take it at its closing edge
      @(posedge clk_i);
      v = rvalid_i;
      d = rdata_i;
   endtask
endmodule
`default_nettype wire

//--- sim/pvs_regs_tb.sv
// Purpose: self-checking bench for the vendor status latch registers
// Assumes: design contract of one-cycle read answer
// Notes:   every scenario is its own task
`timescale 1ns/1ps
`default_nettype none
module pvs_regs_tb;
   import pvs_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   pvs_src_type src_i = '0;
   logic [6:0]  rise_en_i = 7'h00;
   logic [6:0]  fall_en_i = 7'h00;
   logic        lp_i = 1'b0;
   logic        ser_i = 1'b0;
   logic        csc_i = 1'b0;
   pvs_req_type req;
   logic [7:0]  rdata;
   logic        rvalid;
   logic [7:0]  tune;
   int          n_mismatch = 0;
   int          compares = 0;
   int          cycles = 0;

   always #4 clk_i = ~clk_i;

   pvs_regs u_pvs_regs (.clk_i(clk_i), .rstn_i(rstn_i), .req_i(req), .src_i(src_i),
      .rise_en_i(rise_en_i), .fall_en_i(fall_en_i), .lowpower_entry_i(lp_i),
      .serial_entry_i(ser_i), .clock_suspend_control_i(csc_i), .rdata_o(rdata),
      .rvalid_o(rvalid), .tx_tuning_o(tune));
   pvs_link_model u_pvs_link_model (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
      .req_o(req));

   task automatic report_and_stop();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // hang guard: whole run is under a hundred cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
      logic [7:0] d;
      logic       v;
      u_pvs_link_model.reg_read(a, d, v);
      check8({what, " valid"}, 8'h01, {7'h00, v});
      check8(what, exp, d);
   endtask

   task automatic set_src(logic [6:0] v);
      @(posedge clk_i);
      src_i <= v;
   endtask

   task automatic t_reset();
      check8("tuning reset", 8'h41, tune);
      rd_chk("latch reset", PVS_ADDR_LATCH, 8'h00);
      rd_chk("unmapped", 8'h90, 8'h00);
      $display("test reset done");
   endtask

   task automatic t_status();
      set_src(7'h55);
      rd_chk("status 55", PVS_ADDR_STATUS, 8'h55);
      set_src(7'h2a);
      rd_chk("status 2a", PVS_ADDR_STATUS, 8'h2a);
      @(posedge clk_i);
      src_i <= '{bus_power_monitor_ok: 1'b1, default: 1'b0};
      rd_chk("power bit", PVS_ADDR_STATUS, 8'h40);
      @(posedge clk_i);
      src_i <= '{session_valid_comparator: 1'b1, default: 1'b0};
      rd_chk("session", PVS_ADDR_STATUS, 8'h01);
      rd_chk("masked", PVS_ADDR_LATCH, 8'h00);
      $display("test status done");
   endtask

   task automatic t_alias();
      u_pvs_link_model.reg_write(PVS_ADDR_STATUS, 8'hff);
      check8("ro write", 8'h41, tune);
      u_pvs_link_model.reg_write(PVS_ADDR_TUNE_CLR, 8'h01);
      check8("w1c", 8'h40, tune);
      u_pvs_link_model.reg_write(PVS_ADDR_TUNE_CLR, 8'h00);
      rd_chk("alias read", PVS_ADDR_TUNE_CLR, 8'h40);
      $display("test alias done");
   endtask

   task automatic t_latch();
      rise_en_i <= 7'h7f;
      set_src(7'h00);
      set_src(7'h7f);
      rd_chk("rise", PVS_ADDR_LATCH, 8'h7f);
      rd_chk("cleared", PVS_ADDR_LATCH, 8'h00);
      rise_en_i <= 7'h00;
      fall_en_i <= 7'h7f;
      set_src(7'h00);
      rd_chk("fall", PVS_ADDR_LATCH, 8'h7f);
      $display("test latch done");
   endtask

   task automatic t_clears();
      rise_en_i <= 7'h7f;
      for (int i = 0; i < 3; i++) begin
         set_src(~src_i);
         @(posedge clk_i);
         lp_i <= (i == 0);
         ser_i <= (i != 0);
         csc_i <= (i == 2);
         @(posedge clk_i);
         lp_i <= 1'b0;
         ser_i <= 1'b0;
         rd_chk("entry clear", PVS_ADDR_LATCH, 8'h00);
      end
      $display("test clears done");
   endtask

   task automatic t_coincide();
      fork
         set_src(~src_i);
         rd_chk("with read", PVS_ADDR_LATCH, 8'h00);
      join
      rd_chk("kept", PVS_ADDR_LATCH, 8'h7f);
      $display("test coincide done");
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_reset();
      t_status();
      t_alias();
      t_latch();
      t_clears();
      t_coincide();
      report_and_stop();
   end
endmodule
`default_nettype wire
